// ===== hw/uart_channel.sv
// one serial channel: vendor register file, baud timing, framing and flow control
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RL1] software enables tx queue, then tx and rx, then both queues
// [RL2] enable bit 0 gates transmitter, bit 1 gates receiver
// [RL3] bit time from clock via 19-bit divisor and per-direction 16-bit mask
// [RL4] software programs divisor as clock rate over baud, truncated
// [RL5] divisor split over three byte registers, top three bits in third
// [RL6] software indexes the 32-entry lookup by truncated 32 times fraction
// [RL7] receive mask from same index, even or odd divisor column
// [RL8] index 21 gives tx 0x0B6D, rx 0x0B6A even or 0x0DB6 odd
// [RL9] format low nibble picks 7, 8 or 9 data bits
// [RL10] format bits 6..4 pick none, odd, even, mark or space parity
// [RL11] nine data bits means no parity bit at all
// [RL12] format bit 7 picks one or two stop bits, both directions
// [RL13] software writes flow mode only while channel is disabled
// [RL14] flow bits 2..0 pick none, hardware, software, two multidrop modes; code treats both multidrop codes as none
// [RL15] flow bit 3 set drops receive data while transmitting
// [RL16] software mode: resume character received lets transmitter go again
// [RL17] software mode: pause character received holds the transmitter
// [RL18] software keeps reserved upper register bits zero
// [RL19] manager queue enable: tx bit 0, rx bit 1, offsets per channel
// [RL20] register write and multi-read requests, block number picks channel
// [RL21] each set mask bit stretches one bit time by a clock, stepping
// [RL22] frame is start low, data lsb first, parity, stop high; idle high
module uart_channel
  import uart_chan_pkg::*;
#(
  parameter logic [7:0] CHAN_BLOCK = BLK_CHAN0
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire reg_req_s          regReq,
  output reg_rsp_s               regRsp,
  input  wire logic              txValid,
  output logic                   txReady,
  input  wire logic [WORD_W-1:0] txWord,
  output logic                   rxValid,
  input  wire logic              rxReady,
  output logic      [WORD_W-1:0] rxWord,
  input  wire logic              rxLine,
  output logic                   txLine,
  input  wire logic              clearToSend,
  output logic                   readyToSend,
  output logic                   xcvrEnable
);

  typedef struct packed {
    logic [1:0]        en;
    logic [DIV_W-1:0]  div;
    logic [MASK_W-1:0] txMask;
    logic [MASK_W-1:0] rxMask;
    logic [7:0]        fmt;
    logic [3:0]        flow;
    logic [7:0]        resumeChar;
    logic [7:0]        pauseChar;
    logic [1:0]        qen;
    reg_rsp_s          rsp;
    tx_state_e         txState;
    logic [DIV_W:0]    txCnt;
    logic [3:0]        txStep;
    logic [3:0]        txBits;
    logic              txStops;
    logic [8:0]        txShift;
    logic              txOut;
    logic              paused;
    rx_state_e         rxState;
    logic [DIV_W:0]    rxCnt;
    logic [3:0]        rxStep;
    logic [3:0]        rxBits;
    logic              rxStops;
    logic [8:0]        rxShift;
    logic              rxBad;
    logic              rxOutValid;
    logic [8:0]        rxOut;
  } chan_s;

  chan_s q, d;

  logic              qTxValid;
  logic              qTxPop;
  logic [WORD_W-1:0] qTxWord;
  logic              qInReady;
  logic              chanHit;
  logic              mgrHit;
  logic [7:0]        qenOff;
  logic [3:0]        nb;
  logic              txGo;
  logic              txBusy;
  logic              rxOn;
  logic              hdxBlock;
  logic [DIV_W:0]    txNext;
  logic [DIV_W:0]    rxNext;
  logic [8:0]        rxDone;
  logic [7:0]        rdMux;

  // tx words wait here; a full queue stalls the source through txReady
  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_txq (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inValid  (txValid && q.qen[QEN_TX_BIT]),
    .inReady  (qInReady),
    .inData   (txWord),
    .outValid (qTxValid),
    .outReady (qTxPop),
    .outData  (qTxWord)
  );

  assign txReady     = qInReady && q.qen[QEN_TX_BIT]; // RL19
  assign regRsp      = q.rsp;
  assign txLine      = q.txOut;
  assign rxValid     = q.rxOutValid;
  assign rxWord      = q.rxOut;
  assign txBusy      = (q.txState != TX_IDLE);
  assign xcvrEnable  = txBusy;
  assign rxOn        = q.en[EN_RX_BIT] && q.qen[QEN_RX_BIT]; // RL2
  assign readyToSend = rxOn && !q.rxOutValid;
  assign hdxBlock    = q.flow[FLOW_HDX_BIT] && txBusy; // RL15
  assign nb          = dataBits(q.fmt); // RL9
  assign chanHit     = (regReq.block == CHAN_BLOCK); // RL20
  assign mgrHit      = (regReq.block == BLK_MGR);
  assign qenOff      = (CHAN_BLOCK == BLK_CHAN1) ? OFF_QEN_CH1 : OFF_QEN_CH0;
  // pause is only honoured between characters, never mid-frame
  assign txGo        = q.en[EN_TX_BIT] && !q.paused
                       && ((q.flow[2:0] != FLOW_HW) || clearToSend); // RL2 RL14 RL17
  assign qTxPop      = (q.txState == TX_IDLE) && txGo;
  assign txNext      = bitPeriod(q.div, q.txMask, q.txStep + 4'h1) - 1'b1; // RL21
  assign rxNext      = bitPeriod(q.div, q.rxMask, q.rxStep + 4'h1) - 1'b1; // RL21
  assign rxDone      = (nb == 4'h7) ? {2'b00, q.rxShift[6:0]}
                     : (nb == 4'h8) ? {1'b0, q.rxShift[7:0]} : q.rxShift;

  always_comb begin
    rdMux = 8'h00;
    if (chanHit) begin
      case (regReq.addr)
        OFF_ENABLE: rdMux = {6'h00, q.en};
        OFF_DIV0:   rdMux = q.div[7:0];
        OFF_DIV1:   rdMux = q.div[15:8];
        OFF_DIV2:   rdMux = {5'h00, q.div[18:16]};
        OFF_TXM0:   rdMux = q.txMask[7:0];
        OFF_TXM1:   rdMux = q.txMask[15:8];
        OFF_RXM0:   rdMux = q.rxMask[7:0];
        OFF_RXM1:   rdMux = q.rxMask[15:8];
        OFF_FMT:    rdMux = q.fmt;
        OFF_FLOW:   rdMux = {4'h0, q.flow};
        OFF_RESUME: rdMux = q.resumeChar;
        OFF_PAUSE:  rdMux = q.pauseChar;
        default:    rdMux = 8'h00;
      endcase
    end else if (mgrHit && regReq.addr == qenOff) begin
      rdMux = {6'h00, q.qen};
    end
  end

  always_comb begin
    d = q;
    // register port: one answer per read, one cycle after the request
    d.rsp.valid = regReq.rd;
    d.rsp.rdata = regReq.rd ? rdMux : 8'h00;
    if (regReq.wr && chanHit) begin
      case (regReq.addr)
        OFF_ENABLE: d.en = regReq.wdata[1:0]; // RL2
        OFF_DIV0:   d.div[7:0] = regReq.wdata; // RL5
        OFF_DIV1:   d.div[15:8] = regReq.wdata; // RL5
        OFF_DIV2:   d.div[18:16] = regReq.wdata[2:0]; // RL5
        OFF_TXM0:   d.txMask[7:0] = regReq.wdata;
        OFF_TXM1:   d.txMask[15:8] = regReq.wdata;
        OFF_RXM0:   d.rxMask[7:0] = regReq.wdata;
        OFF_RXM1:   d.rxMask[15:8] = regReq.wdata;
        OFF_FMT:    d.fmt = regReq.wdata;
        OFF_FLOW:   d.flow = regReq.wdata[3:0]; // RL14
        OFF_RESUME: d.resumeChar = regReq.wdata;
        OFF_PAUSE:  d.pauseChar = regReq.wdata;
        default:    ;
      endcase
    end
    if (regReq.wr && mgrHit && regReq.addr == qenOff) begin
      d.qen = regReq.wdata[1:0]; // RL19
    end

    // transmitter
    if (!q.en[EN_TX_BIT]) begin
      d.txState = TX_IDLE; // RL2
      d.txOut   = 1'b1;
    end else if (q.txState == TX_IDLE) begin
      d.txOut = 1'b1; // RL22
      if (qTxValid && txGo) begin
        d.txShift = qTxWord;
        d.txState = TX_START;
        d.txOut   = 1'b0; // RL22
        d.txCnt   = bitPeriod(q.div, q.txMask, q.txStep) - 1'b1; // RL3
      end
    end else if (q.txCnt != '0) begin
      d.txCnt = q.txCnt - 1'b1;
    end else begin
      d.txStep = q.txStep + 4'h1; // RL21
      d.txCnt  = txNext;
      unique case (q.txState)
        TX_START: begin
          d.txState = TX_DATA;
          d.txOut   = q.txShift[0]; // RL22
          d.txBits  = 4'h1;
        end
        TX_DATA: begin
          if (q.txBits == nb) begin
            if (parityOn(q.fmt)) begin // RL10 RL11
              d.txState = TX_PAR;
              d.txOut   = parityBit(q.fmt, q.txShift); // RL10
            end else begin
              d.txState = TX_STOP;
              d.txOut   = 1'b1;
              d.txStops = 1'b0;
            end
          end else begin
            d.txOut  = q.txShift[q.txBits];
            d.txBits = q.txBits + 4'h1;
          end
        end
        TX_PAR: begin
          d.txState = TX_STOP;
          d.txOut   = 1'b1;
          d.txStops = 1'b0;
        end
        TX_STOP: begin
          if (q.fmt[FMT_STOP_BIT] && !q.txStops) begin
            d.txStops = 1'b1; // RL12
          end else begin
            d.txState = TX_IDLE;
          end
        end
        default: d.txState = TX_IDLE;
      endcase
    end

    // receiver output register; a new character overwrites an untaken one
    if (q.rxOutValid && rxReady) begin
      d.rxOutValid = 1'b0;
    end
    if (q.flow[2:0] != FLOW_SW) begin
      d.paused = 1'b0;
    end

    if (!rxOn || (hdxBlock && q.rxState != RX_IDLE)) begin
      d.rxState = RX_IDLE; // RL2 RL15
    end else if (q.rxState == RX_IDLE) begin
      if (!rxLine && !hdxBlock) begin // RL15
        d.rxState = RX_START;
        d.rxShift = 9'h000;
        d.rxBad   = 1'b0;
        // first sample lands mid-way into the start bit
        d.rxCnt   = bitPeriod(q.div, q.rxMask, q.rxStep) >> 1;
      end
    end else if (q.rxCnt != '0) begin
      d.rxCnt = q.rxCnt - 1'b1;
    end else begin
      d.rxStep = q.rxStep + 4'h1; // RL21
      d.rxCnt  = rxNext;
      unique case (q.rxState)
        RX_START: begin
          d.rxState = rxLine ? RX_IDLE : RX_DATA; // glitch, not a start bit
          d.rxBits  = 4'h0;
        end
        RX_DATA: begin
          d.rxShift[q.rxBits] = rxLine; // RL22
          d.rxBits            = q.rxBits + 4'h1;
          if (q.rxBits == nb - 4'h1) begin
            d.rxState = parityOn(q.fmt) ? RX_PAR : RX_STOP; // RL11
            d.rxStops = 1'b0;
          end
        end
        RX_PAR: begin
          d.rxState = RX_STOP;
        end
        RX_STOP: begin
          d.rxBad = q.rxBad || !rxLine;
          if (q.fmt[FMT_STOP_BIT] && !q.rxStops) begin
            d.rxStops = 1'b1; // RL12
          end else begin
            d.rxState = RX_IDLE;
            if (!(q.rxBad || !rxLine)) begin
              if (q.flow[2:0] == FLOW_SW && nb != 4'h9
                  && rxDone[7:0] == q.resumeChar) begin
                d.paused = 1'b0; // RL16
              end else if (q.flow[2:0] == FLOW_SW && nb != 4'h9
                           && rxDone[7:0] == q.pauseChar) begin
                d.paused = 1'b1; // RL17
              end else begin
                d.rxOut      = rxDone;
                d.rxOutValid = 1'b1;
              end
            end
          end
        end
        default: d.rxState = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q            <= '0;
      q.en         <= RST_ENABLE;
      q.div        <= RST_DIV;
      q.txMask     <= RST_MASK;
      q.rxMask     <= RST_MASK;
      q.fmt        <= RST_FMT;
      q.flow       <= RST_FLOW;
      q.resumeChar <= RST_CHAR;
      q.pauseChar  <= RST_CHAR;
      q.qen        <= RST_QEN;
      q.txState    <= TX_IDLE;
      q.rxState    <= RX_IDLE;
      q.txOut      <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule : uart_channel
`default_nettype wire

// ===== hw/uart_chan_pkg.sv
// constants, carriers and helpers shared by the serial channel design
package uart_chan_pkg;

  // block numbers carried in the vendor request index high byte
  localparam logic [7:0] BLK_CHAN0 = 8'h00;
  localparam logic [7:0] BLK_CHAN1 = 8'h01;
  localparam logic [7:0] BLK_MGR   = 8'h04;

  // channel register offsets
  localparam logic [7:0] OFF_ENABLE = 8'h03;
  localparam logic [7:0] OFF_DIV0   = 8'h04;
  localparam logic [7:0] OFF_DIV1   = 8'h05;
  localparam logic [7:0] OFF_DIV2   = 8'h06;
  localparam logic [7:0] OFF_TXM0   = 8'h07;
  localparam logic [7:0] OFF_TXM1   = 8'h08;
  localparam logic [7:0] OFF_RXM0   = 8'h09;
  localparam logic [7:0] OFF_RXM1   = 8'h0a;
  localparam logic [7:0] OFF_FMT    = 8'h0b;
  localparam logic [7:0] OFF_FLOW   = 8'h0c;
  localparam logic [7:0] OFF_RESUME = 8'h10;
  localparam logic [7:0] OFF_PAUSE  = 8'h11;
  // manager block queue enables
  localparam logic [7:0] OFF_QEN_CH0 = 8'h10;
  localparam logic [7:0] OFF_QEN_CH1 = 8'h11;

  // field positions
  localparam int EN_TX_BIT    = 0;
  localparam int EN_RX_BIT    = 1;
  localparam int QEN_TX_BIT   = 0;
  localparam int QEN_RX_BIT   = 1;
  localparam int FMT_PAR_LSB  = 4;
  localparam int FMT_STOP_BIT = 7;
  localparam int FLOW_HDX_BIT = 3;

  // data length codes
  localparam logic [3:0] DATA_7 = 4'h7;
  localparam logic [3:0] DATA_8 = 4'h8;
  localparam logic [3:0] DATA_9 = 4'h9;

  // parity codes
  localparam logic [2:0] PAR_NONE  = 3'h0;
  localparam logic [2:0] PAR_ODD   = 3'h1;
  localparam logic [2:0] PAR_EVEN  = 3'h2;
  localparam logic [2:0] PAR_MARK  = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;

  // flow-control modes
  localparam logic [2:0] FLOW_NONE = 3'h0;
  localparam logic [2:0] FLOW_HW   = 3'h1;
  localparam logic [2:0] FLOW_SW   = 3'h2;
  localparam logic [2:0] FLOW_MDHD = 3'h3;
  localparam logic [2:0] FLOW_MDTX = 3'h4;

  // widths and depth
  localparam int DIV_W      = 19;
  localparam int MASK_W     = 16;
  localparam int WORD_W     = 9;
  localparam int FIFO_DEPTH = 4;

  // reset values
  localparam logic [1:0]       RST_ENABLE = 2'h0;
  localparam logic [DIV_W-1:0] RST_DIV    = 19'h001a0;
  localparam logic [15:0]      RST_MASK   = 16'h0000;
  localparam logic [7:0]       RST_FMT    = 8'h08;
  localparam logic [3:0]       RST_FLOW   = 4'h0;
  localparam logic [7:0]       RST_CHAR   = 8'h00;
  localparam logic [1:0]       RST_QEN    = 2'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] block;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_s;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

  // one bit time in clocks: divisor plus one stretch clock when the mask bit is set
  function automatic logic [DIV_W:0] bitPeriod(input logic [DIV_W-1:0]  div,
                                               input logic [MASK_W-1:0] mask,
                                               input logic [3:0]        step);
    logic [DIV_W:0] p;
    p = {1'b0, div} + {{DIV_W{1'b0}}, mask[step]};
    return (p == '0) ? {{DIV_W{1'b0}}, 1'b1} : p;
  endfunction : bitPeriod

  // reserved length codes fall back to eight bits
  function automatic logic [3:0] dataBits(input logic [7:0] fmt);
    unique case (fmt[3:0])
      DATA_7:  return 4'h7;
      DATA_9:  return 4'h9;
      default: return 4'h8;
    endcase
  endfunction : dataBits

  function automatic logic parityOn(input logic [7:0] fmt);
    logic [2:0] p;
    p = fmt[FMT_PAR_LSB +: 3];
    return (fmt[3:0] != DATA_9) && (p != PAR_NONE) && (p <= PAR_SPACE);
  endfunction : parityOn

  function automatic logic parityBit(input logic [7:0] fmt, input logic [8:0] w);
    logic [7:0] v;
    v = (fmt[3:0] == DATA_7) ? {1'b0, w[6:0]} : w[7:0];
    unique case (fmt[FMT_PAR_LSB +: 3])
      PAR_ODD:  return ~^v;
      PAR_EVEN: return ^v;
      PAR_MARK: return 1'b1;
      default:  return 1'b0;
    endcase
  endfunction : parityBit

endpackage : uart_chan_pkg

// ===== hw/word_fifo.sv
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } fifo_s;

  fifo_s q, d;
  logic  push, pop;

  assign inReady  = (q.cnt != DEPTH[PW:0]);
  assign outValid = (q.cnt != '0);
  assign outData  = q.mem[q.rp];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = inData;
      d.wp        = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : word_fifo
`default_nettype wire

// ===== test/uart_channel_sva.sv
// port-level checks for one serial channel
`timescale 1ns/1ps
`default_nettype none
module uart_channel_sva
  import uart_chan_pkg::*;
#(
  parameter logic [7:0] CHAN_BLOCK = BLK_CHAN0
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire reg_req_s          regReq,
  input wire reg_rsp_s          regRsp,
  input wire logic              txValid,
  input wire logic              txReady,
  input wire logic [WORD_W-1:0] txWord,
  input wire logic              rxValid,
  input wire logic              rxReady,
  input wire logic [WORD_W-1:0] rxWord,
  input wire logic              rxLine,
  input wire logic              txLine,
  input wire logic              clearToSend,
  input wire logic              readyToSend,
  input wire logic              xcvrEnable
);
  // shadows of the writes, updated on the same edge as the real registers
  logic [1:0] enQ;
  logic [1:0] qenQ;
  logic [3:0] flowQ;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enQ   <= 2'h0;
      qenQ  <= 2'h0;
      flowQ <= 4'h0;
    end else if (regReq.wr) begin
      if (regReq.block == CHAN_BLOCK && regReq.addr == OFF_ENABLE) enQ <= regReq.wdata[1:0];
      if (regReq.block == CHAN_BLOCK && regReq.addr == OFF_FLOW) flowQ <= regReq.wdata[3:0];
      if (regReq.block == BLK_MGR && regReq.addr == OFF_QEN_CH0 + CHAN_BLOCK) begin
        qenQ <= regReq.wdata[1:0];
      end
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence ctsBlocked;
    flowQ[2:0] == FLOW_HW && !clearToSend && !xcvrEnable;
  endsequence
  sequence rdTaken;
    regReq.rd;
  endsequence
  reset_idle_a: assert property ($rose(rst_n) |-> txLine && !xcvrEnable && !rxValid)
    else $error("line not idle after reset");
  read_answer_a: assert property (rdTaken |=> regRsp.valid)
    else $error("read got no answer");
  no_spurious_a: assert property (!regReq.rd |=> !regRsp.valid && regRsp.rdata == 8'h00)
    else $error("answer without read");
  tx_gate_a: assert property (!enQ[0] |=> txLine)
    else $error("line active with transmitter off");
  rx_gate_a: assert property (!enQ[1] || !qenQ[1] |-> !readyToSend)
    else $error("receiver ready while gated");
  queue_gate_a: assert property (!qenQ[0] |-> !txReady)
    else $error("word taken with tx queue off");
  xcvr_tx_a: assert property (!txLine |-> xcvrEnable)
    else $error("line driven without transceiver enable");
  cts_hold_a: assert property (ctsBlocked |=> !xcvrEnable)
    else $error("character started without clear to send");
  hd_drop_a: assert property (flowQ[3] && xcvrEnable |=> !$rose(rxValid))
    else $error("character received while transmitting");
endmodule : uart_channel_sva
bind uart_channel uart_channel_sva #(.CHAN_BLOCK(CHAN_BLOCK)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .regReq(regReq), .regRsp(regRsp), .txValid(txValid),
  .txReady(txReady), .txWord(txWord), .rxValid(rxValid), .rxReady(rxReady),
  .rxWord(rxWord), .rxLine(rxLine), .txLine(txLine), .clearToSend(clearToSend),
  .readyToSend(readyToSend), .xcvrEnable(xcvrEnable)
);
`default_nettype wire

// ===== test/serial_node.sv
// remote serial node: frames characters onto the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module serial_node (
  input  wire logic ref_clk,
  input  wire logic txLine,
  output logic      rxLine
);
  int per = 8;
  initial rxLine = 1'b1;
  task automatic bit_out(input logic b);
    @(posedge ref_clk) #2 rxLine = b;
    repeat (per - 1) @(posedge ref_clk);
  endtask : bit_out
  // par below zero sends no parity bit; badStop pulls the last stop bit low
  task automatic send(input logic [8:0] w, input int n, input int par, input int stops,
                      input logic badStop);
    bit_out(1'b0);
    for (int i = 0; i < n; i++) bit_out(w[i]);
    if (par >= 0) bit_out(par[0]);
    for (int i = 1; i < stops; i++) bit_out(1'b1);
    bit_out(!badStop);
    @(posedge ref_clk) #2 rxLine = 1'b1;
  endtask : send
  task automatic recv(input int n, input logic par, input int stops, output logic [8:0] w,
                      output logic p, output logic ok);
    w = 9'h000;
    p = 1'b0;
    ok = 1'b1;
    wait (txLine === 1'b0);
    repeat (per / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (per) @(posedge ref_clk);
      w[i] = txLine;
    end
    if (par) begin
      repeat (per) @(posedge ref_clk);
      p = txLine;
    end
    for (int i = 0; i < stops; i++) begin
      repeat (per) @(posedge ref_clk);
      ok &= (txLine === 1'b1);
    end
  endtask : recv
endmodule : serial_node
`default_nettype wire

// ===== test/uart_channel_line_config_bench.sv
// self-checking bench for one serial channel facing a remote node
`timescale 1ns/1ps
`default_nettype none
module uart_channel_line_config_bench
  import uart_chan_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  reg_req_s          regReq = '0;
  reg_rsp_s          regRsp;
  logic              txValid = 1'b0;
  logic              rxReady = 1'b0;
  logic              clearToSend = 1'b1;
  logic [WORD_W-1:0] txWord = '0;
  logic [WORD_W-1:0] rxWord;
  logic              txReady, rxValid, rxLine, txLine, readyToSend, xcvrEnable;
  int                miscompares = 0;
  int                n_tests = 0;
  int                cycles = 0;
  logic [8:0]        w;
  logic              p, ok;

  uart_channel dut (.ref_clk(ref_clk), .rst_n(rst_n), .regReq(regReq), .regRsp(regRsp),
    .txValid(txValid), .txReady(txReady), .txWord(txWord), .rxValid(rxValid),
    .rxReady(rxReady), .rxWord(rxWord), .rxLine(rxLine), .txLine(txLine),
    .clearToSend(clearToSend), .readyToSend(readyToSend), .xcvrEnable(xcvrEnable));
  serial_node node (.ref_clk(ref_clk), .txLine(txLine), .rxLine(rxLine));

  always #12.5 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // the whole run needs a few thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] blk, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #2;
    regReq = '{wr: 1'b1, rd: 1'b0, block: blk, addr: a, wdata: d};
    @(posedge ref_clk) #2;
    regReq = '0;
  endtask : wr

  task automatic rd(input logic [7:0] blk, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk) #2;
    regReq = '{wr: 1'b0, rd: 1'b1, block: blk, addr: a, wdata: 8'h00};
    @(posedge ref_clk) #2;
    regReq = '0;
    chk({regRsp.valid, regRsp.rdata}, {1'b1, exp});
  endtask : rd

  task automatic push(input logic [8:0] d);
    @(posedge ref_clk) #2;
    txValid = 1'b1;
    txWord = d;
    while (txReady !== 1'b1) @(posedge ref_clk) #2;
    @(posedge ref_clk) #2;
    txValid = 1'b0;
  endtask : push

  task automatic take(input logic [8:0] exp);
    for (int k = 0; k < 40 && rxValid !== 1'b1; k++) @(posedge ref_clk) #2;
    chk(rxValid === 1'b1 ? rxWord : 9'hxxx, exp);
    rxReady = 1'b1;
    @(posedge ref_clk) #2;
    rxReady = 1'b0;
  endtask : take

  task automatic none();
    repeat (24) @(posedge ref_clk);
    #2 chk(rxValid, 1'b0);
  endtask : none

  // channel is switched off around the flow write
  task automatic cfg(input logic [7:0] fmt, input logic [7:0] flow);
    wr(BLK_CHAN0, OFF_ENABLE, 8'h00);
    wr(BLK_CHAN0, OFF_FMT, fmt);
    wr(BLK_CHAN0, OFF_FLOW, flow);
    wr(BLK_CHAN0, OFF_ENABLE, 8'h03);
  endtask : cfg

  function automatic logic par_of(input logic [8:0] d, input logic [3:0] n,
                                  input logic [2:0] pm);
    logic x;
    x = ^(n == 4'h7 ? {2'b00, d[6:0]} : {1'b0, d[7:0]});
    return pm == PAR_ODD ? ~x : pm == PAR_EVEN ? x : pm == PAR_MARK;
  endfunction : par_of

  task automatic t_regs();
    logic [15:0] t [16] = '{16'h04a0, 16'h0501, 16'h0605, 16'h076d, 16'h080b, 16'h096a,
      16'h0a0b, 16'h1011, 16'h1113, 16'h0408, 16'h0500, 16'h0600, 16'h0700, 16'h0800,
      16'h0900, 16'h0a00};
    rd(BLK_CHAN0, OFF_FMT, 8'h08);
    rd(BLK_CHAN0, OFF_ENABLE, 8'h00);
    rd(BLK_MGR, OFF_QEN_CH0, 8'h00);
    rd(BLK_CHAN0, 8'h0d, 8'h00);
    rd(8'h02, OFF_FMT, 8'h00);
    chk(txReady, 1'b0);
    foreach (t[i]) begin
      wr(BLK_CHAN0, t[i][15:8], t[i][7:0]);
      rd(BLK_CHAN0, t[i][15:8], t[i][7:0]);
    end
    wr(BLK_MGR, OFF_QEN_CH0, 8'h01);
    wr(BLK_CHAN0, OFF_ENABLE, 8'h03);
    wr(BLK_MGR, OFF_QEN_CH0, 8'h03);
    rd(BLK_MGR, OFF_QEN_CH0, 8'h03);
    chk(readyToSend, 1'b1);
  endtask : t_regs

  task automatic t_fifo();
    wr(BLK_CHAN0, OFF_ENABLE, 8'h02);
    for (int i = 0; i < 4; i++) push(9'(9'h0a0 + i));
    chk(txReady, 1'b0);
    wr(BLK_CHAN0, OFF_ENABLE, 8'h03);
    for (int i = 0; i < 4; i++) begin
      node.recv(8, 1'b0, 1, w, p, ok);
      chk(w, 9'(9'h0a0 + i));
    end
  endtask : t_fifo

  task automatic t_formats();
    logic [7:0] f [7] = '{8'h07, 8'h18, 8'h28, 8'hb8, 8'h48, 8'h19, 8'hc9};
    logic [3:0] n;
    logic       on;
    foreach (f[i]) begin
      n = f[i][3:0];
      on = n != DATA_9 && f[i][6:4] != PAR_NONE;
      cfg(f[i], 8'h00);
      push(9'h1b3);
      node.recv(n, on, f[i][7] + 1, w, p, ok);
      chk(w, 9'h1b3 & ~(9'h1ff << n));
      chk(p, on ? par_of(9'h1b3, n, f[i][6:4]) : 1'b0);
      chk(ok, 1'b1);
    end
  endtask : t_formats

  task automatic t_rx();
    cfg(8'ha8, 8'h00);
    node.send(9'h0c3, 8, 0, 2, 1'b0);
    take(9'h0c3);
    node.send(9'h0c3, 8, 0, 2, 1'b1);
    none();
    wr(BLK_CHAN0, OFF_ENABLE, 8'h01);
    node.send(9'h044, 8, 0, 2, 1'b0);
    none();
    chk(readyToSend, 1'b0);
  endtask : t_rx

  task automatic t_flow();
    cfg(8'h08, 8'h02);
    node.send(9'h013, 8, -1, 1, 1'b0);
    none();
    push(9'h055);
    repeat (40) @(posedge ref_clk);
    #2 chk(xcvrEnable, 1'b0);
    fork
      node.send(9'h011, 8, -1, 1, 1'b0);
      node.recv(8, 1'b0, 1, w, p, ok);
    join
    chk(w, 9'h055);
    chk(rxValid, 1'b0);
    cfg(8'h08, 8'h01);
    clearToSend = 1'b0;
    push(9'h03c);
    repeat (40) @(posedge ref_clk);
    #2 chk(xcvrEnable, 1'b0);
    clearToSend = 1'b1;
    node.recv(8, 1'b0, 1, w, p, ok);
    chk(w, 9'h03c);
  endtask : t_flow

  // the incoming frame lies wholly inside the outgoing one
  task automatic t_half();
    cfg(8'h88, 8'h08);
    fork
      push(9'h066);
      begin
        repeat (6) @(posedge ref_clk);
        node.send(9'h021, 8, -1, 1, 1'b0);
      end
      node.recv(8, 1'b0, 2, w, p, ok);
    join
    chk(w, 9'h066);
    none();
  endtask : t_half

  // divisor 7 with every mask bit set must give eight-cycle bits both ways
  task automatic t_mask();
    wr(BLK_CHAN0, OFF_DIV0, 8'h07);
    for (int i = 0; i < 4; i++) wr(BLK_CHAN0, OFF_TXM0 + 8'(i), 8'hff);
    cfg(8'h08, 8'h00);
    fork
      push(9'h00f);
      node.recv(8, 1'b0, 1, w, p, ok);
    join
    chk(w, 9'h00f);
    node.send(9'h00f, 8, -1, 1, 1'b0);
    take(9'h00f);
  endtask : t_mask

  initial begin
    repeat (16) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    t_regs();
    $display("registers done");
    t_fifo();
    $display("queue done");
    t_formats();
    $display("formats done");
    t_rx();
    $display("receive done");
    t_flow();
    $display("flow control done");
    t_half();
    $display("half duplex done");
    t_mask();
    $display("fraction mask done");
    end_of_test();
  end
endmodule : uart_channel_line_config_bench
`default_nettype wire
